/* File: rtl/pfz_cfg.svh */
// constants for the zone 1 fault-line and input-enable response block
`ifndef PFZ_CFG_SVH
`define PFZ_CFG_SVH
// ****************************************************************
// timing
// ****************************************************************
`define PFZ_CLK_PERIOD_NS  10
`define PFZ_PERSIST_NS     10000
`define PFZ_PERSIST_CYC    ((`PFZ_PERSIST_NS + `PFZ_CLK_PERIOD_NS - 1) / `PFZ_CLK_PERIOD_NS)
// ****************************************************************
// command codes
// ****************************************************************
`define PFZ_CMD_SEL_A      8'hd4
`define PFZ_CMD_SEL_B      8'hd5
`define PFZ_CMD_OV_KILL    8'hd6
`define PFZ_CMD_UV_KILL    8'hd7
`define PFZ_CMD_STATUS     8'h80
`define PFZ_CMD_CLR_STATUS 8'h03
// ****************************************************************
// fields and reset values
// ****************************************************************
`define PFZ_SEL_MSB        3
`define PFZ_SEL_PAD        4'h0
`define PFZ_SEL_RST        4'h0
`define PFZ_KILL_RST       8'h00
`define PFZ_RDATA_IDLE     8'h00
`endif

/* File: rtl/pfz_pkg.sv */
// types shared by the zone 1 fault-line and input-enable response block
package pfz_pkg;
    // ****************************************************************
    // persistence qualifier states, gray along idle-qualify-trip
    // ****************************************************************
    typedef enum logic [1:0] {
        PFZ_IDLE = 2'b00,
        PFZ_QUAL = 2'b01,
        PFZ_TRIP = 2'b11
    } pfz_qual_e;

    // ****************************************************************
    // command port carrier
    // ****************************************************************
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] code;
        logic [7:0] data;
    } pfz_cmd_s;
endpackage : pfz_pkg

/* File: rtl/pfz_zone1_resp.sv */
// zone 1 fault-line shutdown and input-enable pull-down response
//
// Behaviour
// - the upper four bits of both zone 1 select registers are read-only and read as zero.
// - there are two zone 1 select registers of one format, bits 3..0 choosing channels 7..4.
// - a channel whose select bit is 0 keeps running whatever its fault line does.
// - a selected channel is shut down only if its fault line is still low 10us after first seen low.
// - once the line releases the channel is turned back on through its turn-on delay and ramp.
// - an eight-bit setting picks which channels' overvoltage faults kill the input enable.
// - bit n of the overvoltage setting belongs to channel n.
// - a set bit with that channel's fault pulls the input enable low with the fast pull-down.
// - a clear bit never lets that channel's fault disable the input enable.
// - a second eight-bit setting does the same for undervoltage faults.
// - bit n of the undervoltage setting belongs to channel n, 1 pulls low, 0 leaves the pin.
// - a fault-line shutdown drives the alert pin low and sets the channel's status bit.
// - line a answers to the first register, line b to the second, both only for channels 4..7.
`timescale 1ns/1ns
`default_nettype none
`include "pfz_cfg.svh"

module pfz_zone1_resp #(
    parameter int NCH     = 8,
    parameter int PERSIST = `PFZ_PERSIST_CYC
) (
    // clock and reset
    input  wire logic             clk,
    input  wire logic             reset,
    input  wire logic             clk_en,
    // command port
    input  wire pfz_pkg::pfz_cmd_s cmd,
    output var  logic [7:0]       cmd_rdata,
    output var  logic             cmd_rvalid,
    // shared fault lines, active low
    input  wire logic             zone1_shared_fault_line_a_n,
    input  wire logic             zone1_shared_fault_line_b_n,
    // per-channel supervisor faults
    input  wire logic [NCH-1:0]   output_overvoltage_fault,
    input  wire logic [NCH-1:0]   output_undervoltage_fault,
    // channel 4..7 control toward the sequencer
    output var  logic [3:0]       chan_fault_off,
    output var  logic [3:0]       chan_restart,
    // open-drain pins
    output var  logic             alert_pin_n_o,
    output var  logic             alert_pin_n_oe,
    output var  logic             input_enable_o,
    output var  logic             input_enable_oe
);
    localparam int CW = $clog2(PERSIST + 1);
    localparam logic [CW-1:0] LAST = CW'(PERSIST - 1);

    // ****************************************************************
    // state
    // ****************************************************************
    logic [`PFZ_SEL_MSB:0] zone1_line_a_channel_shutdown_select;
    logic [`PFZ_SEL_MSB:0] zone1_line_b_channel_shutdown_select;
    logic [NCH-1:0]        overvoltage_input_enable_kill_select;
    logic [NCH-1:0]        undervoltage_input_enable_kill_select;
    logic [3:0]            line_off_status;
    pfz_pkg::pfz_qual_e    qual [2];
    logic [CW-1:0]         cnt [2];
    logic [1:0]            line_low;
    logic [3:0]            next_off;
    logic                  kill;

    assign line_low = {~zone1_shared_fault_line_b_n, ~zone1_shared_fault_line_a_n};

    function automatic pfz_pkg::pfz_qual_e next_qual(input pfz_pkg::pfz_qual_e st,
                                                     input logic low, input logic done);
        next_qual = pfz_pkg::PFZ_IDLE;
        if (low) begin
            case (st)
                pfz_pkg::PFZ_IDLE: next_qual = pfz_pkg::PFZ_QUAL;
                pfz_pkg::PFZ_QUAL: next_qual = done ? pfz_pkg::PFZ_TRIP : pfz_pkg::PFZ_QUAL;
                pfz_pkg::PFZ_TRIP: next_qual = pfz_pkg::PFZ_TRIP;
                default:           next_qual = pfz_pkg::PFZ_IDLE;
            endcase
        end
    endfunction : next_qual

    // ****************************************************************
    // command registers
    // ****************************************************************
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            zone1_line_a_channel_shutdown_select  <= `PFZ_SEL_RST;
            zone1_line_b_channel_shutdown_select  <= `PFZ_SEL_RST;
            overvoltage_input_enable_kill_select  <= `PFZ_KILL_RST;
            undervoltage_input_enable_kill_select <= `PFZ_KILL_RST;
        end else if (clk_en && cmd.wr) begin
            case (cmd.code)
                // only the low nibble is stored, so reserved bits cannot be set
                `PFZ_CMD_SEL_A:   zone1_line_a_channel_shutdown_select  <= cmd.data[`PFZ_SEL_MSB:0];
                `PFZ_CMD_SEL_B:   zone1_line_b_channel_shutdown_select  <= cmd.data[`PFZ_SEL_MSB:0];
                `PFZ_CMD_OV_KILL: overvoltage_input_enable_kill_select  <= cmd.data;
                `PFZ_CMD_UV_KILL: undervoltage_input_enable_kill_select <= cmd.data;
                default: ;
            endcase
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            cmd_rdata  <= `PFZ_RDATA_IDLE;
            cmd_rvalid <= 1'b0;
        end else if (clk_en) begin
            cmd_rvalid <= cmd.rd;
            case (cmd.code)
                `PFZ_CMD_SEL_A:   cmd_rdata <= {`PFZ_SEL_PAD, zone1_line_a_channel_shutdown_select};
                `PFZ_CMD_SEL_B:   cmd_rdata <= {`PFZ_SEL_PAD, zone1_line_b_channel_shutdown_select};
                `PFZ_CMD_OV_KILL: cmd_rdata <= overvoltage_input_enable_kill_select;
                `PFZ_CMD_UV_KILL: cmd_rdata <= undervoltage_input_enable_kill_select;
                `PFZ_CMD_STATUS:  cmd_rdata <= {line_off_status, `PFZ_SEL_PAD};
                default:          cmd_rdata <= `PFZ_RDATA_IDLE;
            endcase
        end
    end

    // ****************************************************************
    // persistence qualifiers, one per fault line
    // ****************************************************************
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            for (int i = 0; i < 2; i++) begin
                qual[i] <= pfz_pkg::PFZ_IDLE;
                cnt[i]  <= '0;
            end
        end else if (clk_en) begin
            for (int i = 0; i < 2; i++) begin
                qual[i] <= next_qual(qual[i], line_low[i], cnt[i] == LAST);
                // a release before the interval ends drops the count back to zero
                if (qual[i] == pfz_pkg::PFZ_QUAL && line_low[i])
                    cnt[i] <= cnt[i] + CW'(1);
                else
                    cnt[i] <= '0;
            end
        end
    end

    // ****************************************************************
    // channel shutdown and restart
    // ****************************************************************
    always_comb begin
        next_off = '0;
        if (qual[0] == pfz_pkg::PFZ_TRIP)
            next_off = next_off | zone1_line_a_channel_shutdown_select;
        if (qual[1] == pfz_pkg::PFZ_TRIP)
            next_off = next_off | zone1_line_b_channel_shutdown_select;
    end

    // restart is a request; the sequencer applies turn-on delay and ramp
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            chan_fault_off <= '0;
            chan_restart   <= '0;
        end else if (clk_en) begin
            chan_fault_off <= next_off;
            chan_restart   <= chan_fault_off & ~next_off;
        end
    end

    // status sets win over a clear in the same cycle
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            line_off_status <= '0;
            alert_pin_n_o   <= 1'b0;
            alert_pin_n_oe  <= 1'b0;
        end else if (clk_en) begin
            if (cmd.wr && cmd.code == `PFZ_CMD_CLR_STATUS)
                line_off_status <= (next_off & ~chan_fault_off)
                                 | (line_off_status & ~cmd.data[`PFZ_SEL_MSB:0]);
            else
                line_off_status <= line_off_status | (next_off & ~chan_fault_off);
            alert_pin_n_o  <= 1'b0;
            alert_pin_n_oe <= |(next_off & ~chan_fault_off) | (|line_off_status);
        end
    end

    // ****************************************************************
    // input-enable fast pull-down, follows the fault levels
    // ****************************************************************
    assign kill = |(output_overvoltage_fault & overvoltage_input_enable_kill_select)
                | |(output_undervoltage_fault & undervoltage_input_enable_kill_select);

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            input_enable_o  <= 1'b0;
            input_enable_oe <= 1'b0;
        end else if (clk_en) begin
            input_enable_o  <= 1'b0;
            input_enable_oe <= kill;
        end
    end

    // ****************************************************************
    // assertions
    // ****************************************************************
    a_sel_a_reserved: assert property (@(posedge clk) disable iff (reset)
        cmd_rvalid && $past(cmd.code) == `PFZ_CMD_SEL_A |-> cmd_rdata[7:4] == 4'h0)
        else $error("line a select upper bits not zero");
    a_sel_b_reserved: assert property (@(posedge clk) disable iff (reset)
        cmd_rvalid && $past(cmd.code) == `PFZ_CMD_SEL_B |-> cmd_rdata[7:4] == 4'h0)
        else $error("line b select upper bits not zero");
    a_unselected_runs: assert property (@(posedge clk) disable iff (reset || !clk_en)
        (chan_fault_off & ~$past(zone1_line_a_channel_shutdown_select | zone1_line_b_channel_shutdown_select)) == 4'h0)
        else $error("unselected channel shut down");
    a_trip_after_count: assert property (@(posedge clk) disable iff (reset || !clk_en)
        $rose(qual[0] == pfz_pkg::PFZ_TRIP) |-> $past(cnt[0]) == LAST && $past(line_low[0]))
        else $error("line a tripped before persistence count");
    a_glitch_no_trip: assert property (@(posedge clk) disable iff (reset || !clk_en)
        !line_low[1] |=> qual[1] == pfz_pkg::PFZ_IDLE && cnt[1] == '0)
        else $error("line b qualifier not restarted on release");
    a_restart_pulse: assert property (@(posedge clk) disable iff (reset || !clk_en)
        chan_fault_off != 4'h0 && next_off == 4'h0 |=> chan_restart == $past(chan_fault_off) ##1 chan_restart == 4'h0)
        else $error("restart request missing");
    a_alert_on_off: assert property (@(posedge clk) disable iff (reset || !clk_en)
        (next_off & ~chan_fault_off) != 4'h0 |=> alert_pin_n_oe && line_off_status != 4'h0)
        else $error("alert or status missing on shutdown");
    a_ov_pulldown: assert property (@(posedge clk) disable iff (reset || !clk_en)
        |(output_overvoltage_fault & overvoltage_input_enable_kill_select) |=> input_enable_oe && !input_enable_o)
        else $error("overvoltage fault did not pull input enable");
    a_no_kill_idle: assert property (@(posedge clk) disable iff (reset || !clk_en)
        !kill |=> !input_enable_oe)
        else $error("input enable pulled without selected fault");
    a_uv_pulldown: assert property (@(posedge clk) disable iff (reset || !clk_en)
        |(output_undervoltage_fault & undervoltage_input_enable_kill_select) |=> input_enable_oe)
        else $error("undervoltage fault did not pull input enable");

    c_line_a_trip:   cover property (@(posedge clk) disable iff (reset) $rose(qual[0] == pfz_pkg::PFZ_TRIP));
    c_line_b_glitch: cover property (@(posedge clk) disable iff (reset)
        qual[1] == pfz_pkg::PFZ_QUAL ##1 qual[1] == pfz_pkg::PFZ_IDLE);
    c_restart:       cover property (@(posedge clk) disable iff (reset) chan_restart != 4'h0);
    c_kill:          cover property (@(posedge clk) disable iff (reset) $rose(input_enable_oe));
endmodule : pfz_zone1_resp

`default_nettype wire

/* File: dv/pfz_fault_peer.sv */
// model of the other power managers sharing the two zone 1 fault lines
`timescale 1ns/1ns
`default_nettype none

module pfz_fault_peer (
    // requests from the bench to assert a line
    input  wire logic pull_a,
    input  wire logic pull_b,
    // open-drain shared lines, pulled up when nobody drives them
    output var  logic zone1_shared_fault_line_a_n,
    output var  logic zone1_shared_fault_line_b_n
);
    // a released line goes to its pull-up level, never keeps a stale low
    always_comb zone1_shared_fault_line_a_n = pull_a ? 1'b0 : 1'b1;
    always_comb zone1_shared_fault_line_b_n = pull_b ? 1'b0 : 1'b1;
endmodule : pfz_fault_peer

`default_nettype wire

/* File: dv/pfz_zone1_resp_tb_top.sv */
// self-checking bench for the zone 1 fault-line and input-enable response block
`timescale 1ns/1ns
`default_nettype none

module pfz_zone1_resp_tb_top;
    localparam int PER = 8;
    logic              clk = 1'b0;
    logic              reset = 1'b1;
    logic              clk_en = 1'b1;
    pfz_pkg::pfz_cmd_s cmd = '0;
    logic [7:0]        cmd_rdata;
    logic              cmd_rvalid;
    logic              pull_a = 1'b0;
    logic              pull_b = 1'b0;
    logic              line_a_n;
    logic              line_b_n;
    logic [7:0]        ov = 8'h00;
    logic [7:0]        uv = 8'h00;
    logic [3:0]        fault_off;
    logic [3:0]        restart;
    logic              alert_o;
    logic              alert_oe;
    logic              ien_o;
    logic              ien_oe;
    int                errors = 0;
    int                checked = 0;

    always #5 clk = ~clk;

    pfz_fault_peer peer (.pull_a(pull_a), .pull_b(pull_b),
        .zone1_shared_fault_line_a_n(line_a_n), .zone1_shared_fault_line_b_n(line_b_n));

    pfz_zone1_resp #(.PERSIST(PER)) dut (.clk(clk), .reset(reset), .clk_en(clk_en), .cmd(cmd),
        .cmd_rdata(cmd_rdata), .cmd_rvalid(cmd_rvalid),
        .zone1_shared_fault_line_a_n(line_a_n), .zone1_shared_fault_line_b_n(line_b_n),
        .output_overvoltage_fault(ov), .output_undervoltage_fault(uv),
        .chan_fault_off(fault_off), .chan_restart(restart),
        .alert_pin_n_o(alert_o), .alert_pin_n_oe(alert_oe),
        .input_enable_o(ien_o), .input_enable_oe(ien_oe));

    // ****************************************************************
    // checking and closing
    // ****************************************************************
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            errors++;
            $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask : check

    task automatic tally_and_finish();
        $display("checked %0d errors %0d", checked, errors);
        if (errors == 0 && checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : tally_and_finish

    // ****************************************************************
    // command port access
    // ****************************************************************
    task automatic wr(input logic [7:0] code, input logic [7:0] data);
        @(posedge clk);
        cmd <= '{1'b1, 1'b0, code, data};
        @(posedge clk);
        cmd <= '0;
    endtask : wr

    // read answers on the same edge that takes the request
    task automatic rd(input logic [7:0] code, input logic [7:0] exp);
        @(posedge clk);
        cmd <= '{1'b0, 1'b1, code, 8'h00};
        @(posedge clk);
        cmd <= '0;
        #1;
        check({7'h00, cmd_rvalid}, 8'h01);
        check(cmd_rdata, exp);
    endtask : rd

    task automatic step();
        @(posedge clk);
        #1;
    endtask : step

    // hold one line low until the selected channels drop, then release it
    task automatic trip(input logic use_b, input logic [3:0] exp_off, input logic [7:0] exp_stat);
        int n;
        n = 0;
        @(posedge clk);
        if (use_b) pull_b <= 1'b1; else pull_a <= 1'b1;
        while (fault_off === 4'h0 && n < 50) begin
            step();
            n++;
        end
        if (n >= 50) begin
            errors++;
            tally_and_finish();
        end
        check(8'(n), 8'(PER + 2));
        check({4'h0, fault_off}, {4'h0, exp_off});
        check({7'h00, alert_oe}, 8'h01);
        check({7'h00, alert_o}, 8'h00);
        rd(8'h80, exp_stat);
        @(posedge clk);
        pull_a <= 1'b0;
        pull_b <= 1'b0;
        step();
        step();
        check({4'h0, fault_off}, 8'h00);
        check({4'h0, restart}, {4'h0, exp_off});
        step();
        check({4'h0, restart}, 8'h00);
    endtask : trip

    // ****************************************************************
    // main sequence
    // ****************************************************************
    initial begin
        repeat (3) @(posedge clk);
        reset <= 1'b0;
        for (int c = 4; c < 8; c++) rd(8'hd0 + 8'(c), 8'h00);
        // a write while the enable is low must not land
        @(posedge clk);
        clk_en <= 1'b0;
        wr(8'hd6, 8'h3c);
        clk_en <= 1'b1;
        rd(8'hd6, 8'h00);
        wr(8'hd4, 8'hff);
        rd(8'hd4, 8'h0f);
        wr(8'hd5, 8'ha5);
        rd(8'hd5, 8'h05);
        // both kill settings, every channel, own and foreign fault
        for (int k = 0; k < 2; k++) begin
            for (int n = 0; n < 8; n++) begin
                wr(8'hd6 + 8'(k), 8'h01 << n);
                wr(8'hd7 - 8'(k), 8'h00);
                rd(8'hd6 + 8'(k), 8'h01 << n);
                @(posedge clk);
                if (k == 0) ov <= 8'h01 << n; else uv <= 8'h01 << n;
                step();
                check({7'h00, ien_oe}, 8'h01);
                check({7'h00, ien_o}, 8'h00);
                @(posedge clk);
                ov <= (k == 0) ? ~(8'h01 << n) : 8'h00;
                uv <= (k == 1) ? ~(8'h01 << n) : 8'h00;
                step();
                check({7'h00, ien_oe}, 8'h00);
            end
        end
        @(posedge clk);
        ov <= 8'h00;
        uv <= 8'h00;
        // short pulse must not shut anything down
        wr(8'hd4, 8'h05);
        wr(8'hd5, 8'h02);
        @(posedge clk);
        pull_a <= 1'b1;
        pull_b <= 1'b1;
        repeat (PER - 2) @(posedge clk);
        pull_a <= 1'b0;
        pull_b <= 1'b0;
        repeat (PER + 4) step();
        check({4'h0, fault_off}, 8'h00);
        trip(1'b0, 4'h5, 8'h50);
        trip(1'b1, 4'h2, 8'h70);
        wr(8'h03, 8'h0f);
        rd(8'h80, 8'h00);
        check({7'h00, alert_oe}, 8'h00);
        // a second reset in mid-run must bring the settings back to zero
        wr(8'hd6, 8'h81);
        @(posedge clk);
        reset <= 1'b1;
        @(posedge clk);
        reset <= 1'b0;
        rd(8'hd4, 8'h00);
        rd(8'hd6, 8'h00);
        tally_and_finish();
    end
endmodule : pfz_zone1_resp_tb_top

`default_nettype wire
